/* File: dv/sme_exerciser_chk.sv */
// port-level assertions for the storage maintenance exerciser
`timescale 1ns/1ps
`default_nettype none
`include "sme_cfg.svh"
module sme_exerciser_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic irq,
    input wire logic x_gate,
    input wire logic x_drive,
    input wire sme_pkg::sme_select_t sel
);
    import sme_pkg::*;
    logic rd_ph_q, wr_ph_q, odd_seen_q;
    logic [31:0] wa_q;
    logic [13:0] route_q;
    logic [2:0] odd_id_q;
    logic [15:0] odd_age_q;
    wire logic take = hsel && hready && htrans[1];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // snoop the routing register so bank selects can be judged at the pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ph_q <= 1'b0;
            wr_ph_q <= 1'b0;
            route_q <= 14'h0;
        end else begin
            rd_ph_q <= take && !hwrite;
            wr_ph_q <= take && hwrite;
            if (take) wa_q <= haddr;
            if (wr_ph_q && wa_q == `SME_OFF_PRIORITY) route_q <= hwdata[13:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            odd_seen_q <= 1'b0;
            odd_age_q <= 16'h0;
        end else if (sel.select_odd) begin
            odd_seen_q <= 1'b1;
            odd_id_q <= sel.req_id;
            odd_age_q <= 16'h1;
        end else if (odd_age_q != 16'hffff) begin
            odd_age_q <= odd_age_q + 16'h1;
        end
    end
    sequence drive_quiet;
        !x_drive [*8];
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
    AST_RDATA_IDLE: assert property (!rd_ph_q |-> hrdata == 32'h0) else $error("read data outside data phase");
    AST_RST_QUIET: assert property (!$past(rst_n) |-> !irq && !x_gate && !x_drive && sel == '0)
        else $error("outputs active right after reset");
    AST_DRIVE_IN_GATE: assert property (x_drive |-> x_gate) else $error("x drive outside x gate");
    AST_GATE_LEAD: assert property ($rose(x_gate) |-> drive_quiet) else $error("x drive too early");
    AST_DRIVE_LATE: assert property ($rose(x_drive) |-> $past(x_gate, 10)) else $error("x drive lead off");
    AST_SEL_BANK: assert property (sel.select_odd |-> !sel.select_even) else $error("both banks selected");
    AST_SEL_ROUTE: assert property ((sel.select_odd || sel.select_even) |->
        route_q[{sel.req_id, 1'b0} +: 2] == (sel.select_odd ? 2'h1 : 2'h2)) else $error("select against routing");
    AST_SEL_GAP: assert property ((sel.select_even && odd_seen_q && sel.req_id == odd_id_q + 3'h1) |->
        odd_age_q <= 16'd80) else $error("odd to even select gap too long");
endmodule : sme_exerciser_chk
bind sme_exerciser sme_exerciser_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .x_gate(x_gate),
    .x_drive(x_drive), .sel(sel));
`default_nettype wire

/* File: dv/sme_requester_model.sv */
// passive requester side: times x gate periods and odd to even selects
`timescale 1ns/1ps
`default_nettype none
module sme_requester_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic x_gate,
    input wire sme_pkg::sme_select_t sel,
    output logic [15:0] rises,
    output logic [15:0] gap_max,
    output logic [15:0] pairs,
    output logic [15:0] pair_max
);
    import sme_pkg::*;
    logic gate_q, seen_q, odd_q;
    logic [15:0] gap_q, age_q;
    logic [2:0] id_q;
    // requesters only watch x gate and their select pulses; they never push back on the bank
    always_ff @(posedge clk) begin
        gate_q <= x_gate;
        gap_q <= gap_q + 16'h1;
        age_q <= age_q + 16'h1;
        if (clr) begin
            rises <= 16'h0;
            gap_max <= 16'h0;
            pairs <= 16'h0;
            pair_max <= 16'h0;
            seen_q <= 1'b0;
            odd_q <= 1'b0;
        end else begin
            if (x_gate && !gate_q) begin
                rises <= rises + 16'h1;
                seen_q <= 1'b1;
                gap_q <= 16'h1;
                if (seen_q && gap_q > gap_max) gap_max <= gap_q;
            end
            if (sel.select_odd) begin
                odd_q <= 1'b1;
                id_q <= sel.req_id;
                age_q <= 16'h1;
            end
            if (sel.select_even && odd_q && sel.req_id == id_q + 3'h1) begin
                pairs <= pairs + 16'h1;
                if (age_q > pair_max) pair_max <= age_q;
            end
        end
    end
endmodule : sme_requester_model
`default_nettype wire

/* File: dv/test_storage_maintenance_exerciser.sv */
// self-checking bench for the storage maintenance exerciser
`timescale 1ns/1ps
`default_nettype none
`include "sme_cfg.svh"
module test_storage_maintenance_exerciser;
    import sme_pkg::*;
    localparam logic [31:0] c_start = 32'h1 << `SME_CTRL_START;
    localparam logic [31:0] c_stop = 32'h1 << `SME_CTRL_STOP;
    localparam logic [31:0] c_reset = 32'h1 << `SME_CTRL_RESET;
    localparam logic [31:0] c_fetch = 32'h1 << `SME_CTRL_FETCH;
    localparam logic [31:0] c_single = 32'h1 << `SME_CTRL_SINGLE;
    localparam logic [31:0] c_tas = 32'h1 << `SME_CTRL_TAS;
    localparam logic [31:0] c_cancel = 32'h1 << `SME_CTRL_CANCEL;
    localparam logic [31:0] c_soc = 32'h1 << `SME_CTRL_STOP_ON_CHK;
    localparam logic [31:0] c_logs = 32'h1 << `SME_CTRL_LOG_STOP;
    localparam logic [31:0] c_rpb = 32'h1 << `SME_CTRL_REV_PB;
    localparam logic [31:0] c_rpa = 32'h1 << `SME_CTRL_REV_PA;
    localparam logic [31:0] c_auto = 32'h1 << `SME_CTRL_AUTO_RESET;
    localparam logic [31:0] c_keyset = 32'h1 << `SME_CTRL_KEY_SET;
    localparam logic [31:0] c_prio = 32'h1 << `SME_CTRL_PRIORITY;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd2;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irq, x_gate, x_drive;
    sme_select_t sel;
    logic [15:0] rises, gap_max, pairs, pair_max;
    int failures = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    sme_exerciser dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .x_gate(x_gate), .x_drive(x_drive), .sel(sel));
    sme_requester_model u_req (.clk(clk), .clr(clr), .x_gate(x_gate), .sel(sel), .rises(rises),
        .gap_max(gap_max), .pairs(pairs), .pair_max(pair_max));
    task automatic conclude;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // no wait count assumed; the watchdog ends a hung bus
    task automatic hold;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : hold
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hold();
        htrans <= 2'h0;
        hwdata <= d;
        hold();
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rdv(input logic [31:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rdv
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        rdv(`SME_OFF_IRQ_STAT, r);
        cmp(r & m, e);
    endtask : st
    // reset pulse first so each run starts from address zero with clean checks
    task automatic go(input logic [31:0] c);
        wr(`SME_OFF_CTRL, c | c_reset);
        wr(`SME_OFF_IRQ_STAT, 32'h7f);
        wr(`SME_OFF_CTRL, c | c_start);
    endtask : go
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        cyc(5);
        rst_n <= 1'b1;
        clr <= 1'b0;
        cyc(1);
        rdv(`SME_OFF_STATUS, rd);
        cmp(rd & 32'h3c0, 32'h40);
        rdv(`SME_OFF_DATA_KEYS, rd);
        cmp(rd, 32'h1ff);
        rdv(32'h40, rd);
        cmp(rd, 32'h0);
        go(c_single);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(400);
        cmp({16'h0, rises}, 32'h1);
        st(32'h40, 32'h40);
        wr(`SME_OFF_IRQ_MASK, 32'h40);
        cyc(1);
        cmp({31'h0, irq}, 32'h1);
        wr(`SME_OFF_IRQ_MASK, 32'h0);
        cyc(1);
        cmp({31'h0, irq}, 32'h0);
        wr(`SME_OFF_IRQ_MASK, 32'h40);
        wr(`SME_OFF_IRQ_STAT, 32'h7f);
        cyc(1);
        cmp({31'h0, irq}, 32'h0);
        st(32'h7f, 32'h0);
        wr(`SME_OFF_IRQ_MASK, 32'h0);
        go(32'h0);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(600);
        cmp({16'h0, gap_max}, 32'd160);
        cmp({31'h0, rises > 16'd2}, 32'h1);
        wr(`SME_OFF_CTRL, c_stop);
        cyc(200);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(400);
        cmp({16'h0, rises}, 32'h0);
        wr(`SME_OFF_PRIORITY, 32'h2640);
        go(c_prio | c_fetch);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(800);
        cmp({31'h0, pairs > 16'h0}, 32'h1);
        cmp({31'h0, pair_max <= 16'd80}, 32'h1);
        wr(`SME_OFF_CTRL, c_stop);
        wr(`SME_OFF_ADDR_KEYS, 32'h000f_ffe0);
        // cancelled store run long enough to carry the counter into bit 5
        go(c_cancel);
        cyc(5300);
        rdv(`SME_OFF_ADDR_CTR, rd);
        cmp(rd & 32'h000f_ffe0, 32'h0);
        go(c_tas | c_single | c_fetch);
        cyc(400);
        wr(`SME_OFF_CTRL, c_tas | c_single | c_fetch | c_start);
        cyc(400);
        rdv(`SME_OFF_DATA_BUS, rd);
        cmp(rd & 32'h0000_00ff, 32'h0000_00ff);
        rdv(`SME_OFF_STATUS, rd);
        cmp(rd & 32'h0000_3c00, 32'h0000_3c00);
        st(32'h1, 32'h1);
        rdv(`SME_OFF_ADDR_CTR, rd);
        cmp(rd & 32'h000f_ffe0, 32'h0);
        go(c_single);
        cyc(400);
        wr(`SME_OFF_DATA_KEYS, 32'h100);
        go(c_single | c_cancel);
        cyc(400);
        wr(`SME_OFF_DATA_KEYS, 32'h1ff);
        go(c_single | c_fetch);
        cyc(400);
        rdv(`SME_OFF_DATA_BUS, rd);
        cmp(rd, 32'hffff_ffff);
        wr(`SME_OFF_DATA_KEYS, 32'h11f);
        go(c_single | c_fetch | c_logs);
        cyc(400);
        st(32'h10, 32'h10);
        rdv(`SME_OFF_DATA_BUS, rd);
        cmp(rd, 32'hffff_ffff);
        wr(`SME_OFF_DATA_KEYS, 32'h1ff);
        go(c_fetch | c_tas | c_keyset | c_single);
        cyc(400);
        st(32'h20, 32'h20);
        wr(`SME_OFF_ADDR_KEYS, 32'h0);
        go(c_soc);
        cyc(200);
        wr(`SME_OFF_CTRL, c_soc | c_rpb);
        cyc(400);
        st(32'ha, 32'ha);
        wr(`SME_OFF_DATA_KEYS, 32'h100);
        go(c_rpa);
        cyc(400);
        st(32'he, 32'he);
        rdv(`SME_OFF_STATUS, rd);
        cmp(rd & 32'h3c0, 32'h200);
        wr(`SME_OFF_CTRL, c_rpa | c_auto);
        cyc(400);
        rdv(`SME_OFF_ADDR_CTR, rd);
        cyc(480);
        rdv(`SME_OFF_ADDR_CTR, rd2);
        cmp({31'h0, rd2 !== rd}, 32'h1);
        wr(`SME_OFF_CTRL, c_stop);
        conclude();
    end
endmodule : test_storage_maintenance_exerciser
`default_nettype wire

/* File: shared/sme_cfg.svh */
// timing and layout constants for the storage maintenance exerciser
`ifndef SME_CFG_SVH
`define SME_CFG_SVH
`define SME_CLK_PERIOD_PS 5000
`define SME_SELECT_GAP_NS 400
`define SME_SELECT_GAP_CYC ((`SME_SELECT_GAP_NS * 1000) / `SME_CLK_PERIOD_PS)
`define SME_XGATE_PERIOD_NS 800
`define SME_XGATE_PERIOD_CYC ((`SME_XGATE_PERIOD_NS * 1000) / `SME_CLK_PERIOD_PS)
`define SME_XGATE_ON_CYC 80
`define SME_XDRIVE_START_CYC 10
`define SME_XDRIVE_LEN_CYC 40
`define SME_CTR_W 8
`define SME_ADDR_W 24
`define SME_KEY_LO 5
`define SME_KEY_HI 19
`define SME_BYTE3_LO 24
`define SME_MEM_DEPTH 256
`define SME_REQ_N 7
`define SME_IRQ_W 7
`define SME_IRQ_COMPARE 0
`define SME_IRQ_SAR_EVEN 1
`define SME_IRQ_PROT_ADDR 2
`define SME_IRQ_TEST_STOP 3
`define SME_IRQ_LOG_STOP 4
`define SME_IRQ_MULTI_ACC 5
`define SME_IRQ_CYCLE 6
`define SME_OFF_CTRL 32'h0000_0000
`define SME_OFF_ADDR_KEYS 32'h0000_0004
`define SME_OFF_DATA_KEYS 32'h0000_0008
`define SME_OFF_PRIORITY 32'h0000_000c
`define SME_OFF_STATUS 32'h0000_0010
`define SME_OFF_IRQ_STAT 32'h0000_0014
`define SME_OFF_IRQ_MASK 32'h0000_0018
`define SME_OFF_DATA_BUS 32'h0000_001c
`define SME_OFF_ADDR_CTR 32'h0000_0020
`define SME_CTRL_START 0
`define SME_CTRL_STOP 1
`define SME_CTRL_RESET 2
`define SME_CTRL_FETCH 3
`define SME_CTRL_SINGLE 4
`define SME_CTRL_TAS 5
`define SME_CTRL_CANCEL 6
`define SME_CTRL_STOP_ON_CHK 7
`define SME_CTRL_LOG_STOP 8
`define SME_CTRL_REV_PB 9
`define SME_CTRL_REV_PA 10
`define SME_CTRL_AUTO_RESET 11
`define SME_CTRL_KEY_SET 12
`define SME_CTRL_EVEN 13
`define SME_CTRL_PRIORITY 14
`endif

/* File: shared/sme_pkg.sv */
// types shared by the storage maintenance exerciser
package sme_pkg;
    typedef enum logic [3:0] {
        SME_IDLE = 4'h1,
        SME_CYCLE = 4'h2,
        SME_WAIT = 4'h4,
        SME_STOPPED = 4'h8
    } sme_state_t;

    typedef enum logic [1:0] {
        SME_BANK_OFF = 2'h0,
        SME_BANK_ODD = 2'h1,
        SME_BANK_EVEN = 2'h2
    } sme_bank_t;

    typedef struct packed {
        logic compare;
        logic sar_even;
        logic prot_addr;
        logic test_stop;
        logic log_stop;
        logic multi_acc;
    } sme_checks_t;

    typedef struct packed {
        logic select_odd;
        logic select_even;
        logic [2:0] req_id;
    } sme_select_t;
endpackage : sme_pkg

/* File: verilog/sme_exerciser.sv */
// storage maintenance exerciser top with ahb-lite register slave
// Contract
// - test-and-set fetch in single cycle returns byte 0 all ones with parity and raises compare check on the second start.
// - address keys 5-19 can force those address bits to zero instead of the counter value.
// - reversed parity on half b during store with stop-on-check raises even address check and test stop.
// - reversed parity on half a raises even address check, protect address check and test stop together.
// - auto reset mode clears an address-check stop taken in manual mode and resumes stepping.
// - odd select of one requester to even select of the next is at most 400 ns.
// - x gate rises 800 ns apart in free run, one clock later across an auto reset stop, and x drive lies inside the gate window.
// - priority settings route each requester to odd, even or off individually.
`timescale 1ns/1ps
`default_nettype none
`include "sme_cfg.svh"
module sme_exerciser (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic x_gate,
    output logic x_drive,
    output sme_pkg::sme_select_t sel
);
    import sme_pkg::*;
    localparam int AW = `SME_ADDR_W;

    logic [15:0] ctrl_q;
    logic [AW-1:0] addr_keys_q;
    logic [8:0] data_keys_q;
    logic [13:0] routing_q;
    logic [6:0] irq_stat_q;
    logic [6:0] irq_mask_q;
    logic [AW-1:0] addr_ctr_q;
    logic [35:0] data_bus_q;
    logic [8:0] mem_q [`SME_MEM_DEPTH];
    sme_state_t state_q;
    sme_checks_t chk_q;
    logic run;
    logic cycle_end;
    logic [AW-1:0] eff_addr;
    logic [8:0] rd_byte;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [5:0] wr_idx_q;
    logic start_pulse;
    logic stop_pulse;
    logic reset_pulse;
    logic tas_second_q;
    logic [6:0] ev;
    logic stop_cause;

    // byte parity bit over 8 data bits, odd parity
    function automatic logic par_bit(input logic [7:0] b);
        par_bit = ~(^b);
    endfunction : par_bit

    function automatic logic reg_hit(input logic [5:0] idx, input logic [31:0] off);
        reg_hit = idx == off[7:2];
    endfunction : reg_hit

    // bus slave: zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            rd_pend_q <= hsel && htrans[1] && !hwrite;
            wr_idx_q <= haddr[7:2];
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_q) begin
            case (wr_idx_q)
                6'h00: hrdata = {16'h0000, ctrl_q};
                6'h01: hrdata = {8'h00, addr_keys_q};
                6'h02: hrdata = {23'h000000, data_keys_q};
                6'h03: hrdata = {18'h00000, routing_q};
                6'h04: hrdata = {18'h0, data_bus_q[35], data_bus_q[26], data_bus_q[17], data_bus_q[8], state_q, chk_q};
                6'h05: hrdata = {25'h0000000, irq_stat_q};
                6'h06: hrdata = {25'h0000000, irq_mask_q};
                6'h07: hrdata = {data_bus_q[34:27], data_bus_q[25:18], data_bus_q[16:9], data_bus_q[7:0]};
                6'h08: hrdata = {8'h00, eff_addr};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // start, stop and reset bits are self-clearing pulses
    assign start_pulse = wr_pend_q && reg_hit(wr_idx_q, `SME_OFF_CTRL) && hwdata[`SME_CTRL_START];
    assign stop_pulse = wr_pend_q && reg_hit(wr_idx_q, `SME_OFF_CTRL) && hwdata[`SME_CTRL_STOP];
    assign reset_pulse = wr_pend_q && reg_hit(wr_idx_q, `SME_OFF_CTRL) && hwdata[`SME_CTRL_RESET];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= 16'h0000;
            addr_keys_q <= '0;
            data_keys_q <= 9'h1ff;
            routing_q <= 14'h0000;
            irq_mask_q <= 7'h00;
        end else if (wr_pend_q) begin
            if (reg_hit(wr_idx_q, `SME_OFF_CTRL)) ctrl_q <= {hwdata[15:3], 3'h0};
            if (reg_hit(wr_idx_q, `SME_OFF_ADDR_KEYS)) addr_keys_q <= hwdata[AW-1:0];
            if (reg_hit(wr_idx_q, `SME_OFF_DATA_KEYS)) data_keys_q <= hwdata[8:0];
            if (reg_hit(wr_idx_q, `SME_OFF_PRIORITY)) routing_q <= hwdata[13:0];
            if (reg_hit(wr_idx_q, `SME_OFF_IRQ_MASK)) irq_mask_q <= hwdata[6:0];
        end
    end

    // force-zero keys pin the address bits they cover
    assign eff_addr = addr_ctr_q & ~(addr_keys_q & {{(AW-`SME_KEY_HI-1){1'b0}},
        {(`SME_KEY_HI-`SME_KEY_LO+1){1'b1}}, {`SME_KEY_LO{1'b0}}});

    assign rd_byte = mem_q[eff_addr[`SME_CTR_W-1:0]];
    assign run = state_q == SME_CYCLE;

    // check causes other than log stop evaluated at the end of each storage cycle
    always_comb begin
        ev = 7'h00;
        if (cycle_end) begin
            ev[`SME_IRQ_CYCLE] = 1'b1;
            if (ctrl_q[`SME_CTRL_REV_PB] || ctrl_q[`SME_CTRL_REV_PA]) ev[`SME_IRQ_SAR_EVEN] = 1'b1;
            if (ctrl_q[`SME_CTRL_REV_PA]) ev[`SME_IRQ_PROT_ADDR] = 1'b1;
            if (ctrl_q[`SME_CTRL_FETCH] && ctrl_q[`SME_CTRL_TAS] && tas_second_q) ev[`SME_IRQ_COMPARE] = 1'b1;
            if (ctrl_q[`SME_CTRL_FETCH] && !ctrl_q[`SME_CTRL_TAS] && rd_byte != data_keys_q)
                ev[`SME_IRQ_COMPARE] = 1'b1;
            if (ctrl_q[`SME_CTRL_FETCH] && ctrl_q[`SME_CTRL_TAS] && ctrl_q[`SME_CTRL_KEY_SET])
                ev[`SME_IRQ_MULTI_ACC] = 1'b1;
        end
        if (ctrl_q[`SME_CTRL_LOG_STOP] && data_keys_q[7:5] != 3'h7) ev[`SME_IRQ_LOG_STOP] = 1'b1;
        // reverse parity on half a always stops the exerciser; on half b only with stop-on-check
        ev[`SME_IRQ_TEST_STOP] = (ev[`SME_IRQ_SAR_EVEN] && ctrl_q[`SME_CTRL_STOP_ON_CHK])
            || ev[`SME_IRQ_PROT_ADDR] || (ev[`SME_IRQ_COMPARE] && ctrl_q[`SME_CTRL_STOP_ON_CHK]);
    end

    assign stop_cause = ev[`SME_IRQ_TEST_STOP] || ev[`SME_IRQ_LOG_STOP];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= SME_IDLE;
        end else begin
            case (state_q)
                SME_IDLE: if (start_pulse) state_q <= SME_CYCLE;
                SME_CYCLE: begin
                    if (stop_cause) state_q <= SME_STOPPED;
                    else if (stop_pulse || reset_pulse) state_q <= SME_IDLE;
                    else if (cycle_end && ctrl_q[`SME_CTRL_SINGLE]) state_q <= SME_WAIT;
                end
                SME_WAIT: begin
                    if (start_pulse) state_q <= SME_CYCLE;
                    else if (stop_pulse || reset_pulse) state_q <= SME_IDLE;
                end
                SME_STOPPED: begin
                    if (ctrl_q[`SME_CTRL_AUTO_RESET] && !chk_q.log_stop) state_q <= SME_CYCLE;
                    else if (reset_pulse) state_q <= SME_IDLE;
                end
                default: state_q <= SME_IDLE;
            endcase
        end
    end

    // checks except log stop are held for the panel; reset clears them, auto mode re-arms
    always_ff @(posedge clk) begin
        if (!rst_n || reset_pulse) begin
            chk_q <= '0;
        end else begin
            if (ev[`SME_IRQ_COMPARE]) chk_q.compare <= 1'b1;
            if (ev[`SME_IRQ_SAR_EVEN]) chk_q.sar_even <= 1'b1;
            if (ev[`SME_IRQ_PROT_ADDR]) chk_q.prot_addr <= 1'b1;
            if (ev[`SME_IRQ_MULTI_ACC]) chk_q.multi_acc <= 1'b1;
            chk_q.log_stop <= ev[`SME_IRQ_LOG_STOP];
            if (stop_cause) chk_q.test_stop <= 1'b1;
            else if (state_q == SME_STOPPED && ctrl_q[`SME_CTRL_AUTO_RESET]) chk_q.test_stop <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || reset_pulse) begin
            addr_ctr_q <= '0;
            tas_second_q <= 1'b0;
        end else if (cycle_end && (!stop_cause || ctrl_q[`SME_CTRL_AUTO_RESET])) begin
            addr_ctr_q <= addr_ctr_q + AW'(1);
            tas_second_q <= ctrl_q[`SME_CTRL_TAS] && ctrl_q[`SME_CTRL_FETCH];
        end
    end

    always_ff @(posedge clk) begin
        if (cycle_end && !ctrl_q[`SME_CTRL_FETCH] && !ctrl_q[`SME_CTRL_CANCEL]) begin
            mem_q[eff_addr[`SME_CTR_W-1:0]] <= data_keys_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_bus_q <= '0;
        end else if (ev[`SME_IRQ_LOG_STOP] || chk_q.log_stop) begin
            data_bus_q <= data_bus_q;
        end else if (cycle_end && ctrl_q[`SME_CTRL_FETCH]) begin
            if (ctrl_q[`SME_CTRL_TAS] && tas_second_q) begin
                data_bus_q <= {par_bit(8'h00), 8'h00, par_bit(8'h00), 8'h00, par_bit(8'h00), 8'h00,
                    par_bit(8'hff), 8'hff};
            end else begin
                data_bus_q <= {4{rd_byte}};
            end
        end else if (cycle_end) begin
            data_bus_q <= '0;
        end
    end

    // status bits: hardware set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat_q <= 7'h00;
        end else if (wr_pend_q && reg_hit(wr_idx_q, `SME_OFF_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~hwdata[6:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    sme_xgate u_xgate (
        .clk(clk),
        .rst_n(rst_n),
        .run(run),
        .x_gate(x_gate),
        .x_drive(x_drive),
        .cycle_end(cycle_end)
    );

    sme_priority u_priority (
        .clk(clk),
        .rst_n(rst_n),
        .go(run && ctrl_q[`SME_CTRL_PRIORITY]),
        .routing(routing_q),
        .sel(sel)
    );
endmodule : sme_exerciser
`default_nettype wire

/* File: verilog/sme_priority.sv */
// priority routing of requesters to odd and even banks
`timescale 1ns/1ps
`default_nettype none
`include "sme_cfg.svh"
module sme_priority (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [13:0] routing,
    output sme_pkg::sme_select_t sel
);
    import sme_pkg::*;
    logic [2:0] idx_q;
    logic [6:0] gap_q;
    sme_bank_t bank;

    assign bank = sme_bank_t'(routing[2*idx_q +: 2]);

    always_ff @(posedge clk) begin
        if (!rst_n || !go) begin
            idx_q <= 3'h0;
            gap_q <= 7'h00;
            sel <= '0;
        end else begin
            sel <= '0;
            if (gap_q != 7'h00) begin
                gap_q <= gap_q - 7'h01;
            end else begin
                // one requester per slot keeps select spacing well under the limit
                gap_q <= 7'(`SME_SELECT_GAP_CYC / 2 - 1);
                idx_q <= (idx_q == 3'(`SME_REQ_N - 1)) ? 3'h0 : idx_q + 3'h1;
                sel.req_id <= idx_q;
                sel.select_odd <= bank == SME_BANK_ODD;
                sel.select_even <= bank == SME_BANK_EVEN;
            end
        end
    end
endmodule : sme_priority
`default_nettype wire

/* File: verilog/sme_xgate.sv */
// x gate and x drive timing generator, one period per storage cycle
`timescale 1ns/1ps
`default_nettype none
`include "sme_cfg.svh"
module sme_xgate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic x_gate,
    output logic x_drive,
    output logic cycle_end
);
    import sme_pkg::*;
    localparam logic [7:0] PERIOD = 8'(`SME_XGATE_PERIOD_CYC);
    logic [7:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == PERIOD - 8'h01) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            x_gate <= 1'b0;
            x_drive <= 1'b0;
            cycle_end <= 1'b0;
        end else begin
            x_gate <= run && cnt_q < 8'(`SME_XGATE_ON_CYC);
            // drive sits strictly inside the gate window
            x_drive <= run && cnt_q >= 8'(`SME_XDRIVE_START_CYC)
                && cnt_q < 8'(`SME_XDRIVE_START_CYC + `SME_XDRIVE_LEN_CYC);
            // raised in the last count so run falls on the wrap and no stray gate pulse starts
            cycle_end <= run && cnt_q == PERIOD - 8'h02;
        end
    end
endmodule : sme_xgate
`default_nettype wire
